// >>> design/irc_codec.sv
// Infrared pulse encoder and decoder between a UART and a transceiver
module irc_codec
   import irc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic codec_enable,
   input wire logic oversample_tick,
   input wire logic uart_tx_in,
   input wire logic ir_rx_in,
   output logic ir_tx_out,
   output logic uart_rx_out,
   output logic tx_overflow
);
   irc_sync_s tx_pin, next_tx_pin;
   irc_sync_s rx_pin, next_rx_pin;
   logic enable, next_enable;
   irc_tx_state_e tx_state, next_tx_state;
   logic [3:0] tx_cnt, next_tx_cnt;
   logic [4:0] rx_cnt, next_rx_cnt;
   logic rx_busy, next_rx_busy;
   logic ir_tx, next_ir_tx;
   logic uart_rx, next_uart_rx;
   logic ovf, next_ovf;
   logic tx_fall, rx_fall;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [IRC_EDGE_W-1:0] fifo_out_data;

   function automatic logic fall_of(input irc_sync_s p);
      fall_of = p.last && !p.sync;
   endfunction

   // Pin synchronisers, first stage read only by second
   always_comb begin
      next_tx_pin.meta = uart_tx_in;
      next_tx_pin.sync = tx_pin.meta;
      next_tx_pin.last = tx_pin.sync;
      next_rx_pin.meta = ir_rx_in;
      next_rx_pin.sync = rx_pin.meta;
      next_rx_pin.last = rx_pin.sync;
      next_enable = codec_enable;
      tx_fall = fall_of(tx_pin);
      rx_fall = fall_of(rx_pin);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_pin <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
         rx_pin <= '{meta: 1'b1, sync: 1'b1, last: 1'b1};
         enable <= IRC_ENABLE_RST;
      end else begin
         tx_pin <= next_tx_pin;
         rx_pin <= next_rx_pin;
         enable <= next_enable;
      end
   end

   // Falling edges of the transmit line are queued until the encoder is free
   irc_fifo #(
      .WIDTH(IRC_EDGE_W),
      .DEPTH(IRC_FIFO_DEPTH)
   ) u_edge_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_data(tx_fall),
      .in_valid(tx_fall && enable),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );

   // Encoder: delay then fixed pulse, per falling edge
   always_comb begin
      next_tx_state = tx_state;
      next_tx_cnt = tx_cnt;
      next_ir_tx = IRC_TX_IDLE;
      fifo_pop = 1'b0;
      next_ovf = ovf | (tx_fall && enable && !fifo_in_ready);
      unique case (tx_state)
         IRC_TX_WAIT_E: begin
            if (fifo_out_valid && fifo_out_data[0]) begin
               fifo_pop = 1'b1;
               next_tx_cnt = '0;
               next_tx_state = IRC_TX_DELAY_E;
            end
         end
         IRC_TX_DELAY_E: begin
            if (oversample_tick) begin
               next_tx_cnt = 4'(tx_cnt + 1'b1);
               if (tx_cnt == IRC_TX_DELAY - 4'h1) begin
                  next_tx_cnt = '0;
                  next_tx_state = IRC_TX_HIGH_E;
               end
            end
         end
         IRC_TX_HIGH_E: begin
            next_ir_tx = 1'b1;
            if (oversample_tick) begin
               next_tx_cnt = 4'(tx_cnt + 1'b1);
               if (tx_cnt == IRC_TX_PULSE - 4'h1) begin
                  next_ir_tx = IRC_TX_IDLE;
                  next_tx_cnt = '0;
                  next_tx_state = IRC_TX_WAIT_E;
               end
            end
         end
         default: begin
            next_tx_state = IRC_TX_WAIT_E;
         end
      endcase
      if (!enable) begin
         next_tx_state = IRC_TX_WAIT_E;
         next_ir_tx = IRC_TX_IDLE;
         fifo_pop = fifo_out_valid;
         next_ovf = 1'b0;
      end
   end

   // Decoder: stretch each pulse that arrives while idle to one bit time
   always_comb begin
      next_rx_busy = rx_busy;
      next_rx_cnt = rx_cnt;
      next_uart_rx = uart_rx;
      if (!rx_busy) begin
         if (rx_fall) begin
            next_rx_busy = 1'b1;
            next_rx_cnt = '0;
            next_uart_rx = 1'b0;
         end
      end else if (oversample_tick) begin
         next_rx_cnt = 5'(rx_cnt + 1'b1);
         if (rx_cnt == IRC_BIT_TICKS - 5'h01) begin
            next_rx_busy = 1'b0;
            next_uart_rx = IRC_RX_IDLE;
         end
      end
      if (!enable) begin
         next_rx_busy = 1'b0;
         next_uart_rx = IRC_RX_IDLE;
      end
   end

   // Encoder and decoder registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_state <= IRC_TX_WAIT_E;
         tx_cnt <= '0;
         ir_tx <= IRC_TX_IDLE;
         ovf <= 1'b0;
         rx_busy <= 1'b0;
         rx_cnt <= '0;
         uart_rx <= IRC_RX_IDLE;
      end else begin
         tx_state <= next_tx_state;
         tx_cnt <= next_tx_cnt;
         ir_tx <= next_ir_tx;
         ovf <= next_ovf;
         rx_busy <= next_rx_busy;
         rx_cnt <= next_rx_cnt;
         uart_rx <= next_uart_rx;
      end
   end

   assign ir_tx_out = ir_tx;
   assign uart_rx_out = uart_rx;
   assign tx_overflow = ovf;
endmodule

// >>> design/irc_pkg.sv
// Constants and carrier types for the infrared pulse codec
//
// Summary of operation
// - Encoder and decoder run on sys_clk; their counters advance only on cycles with the oversample tick.
// - Each falling edge of the UART transmit input that finds room in the 8-entry queue gives one infrared pulse, so a run of low bits gives only one.
// - After a falling edge of the UART transmit input the encoder waits 7 ticks before the pulse.
// - The infrared pulse stays high for exactly 3 ticks, then returns low.
// - A falling edge on the infrared receive input while no stretch is running starts a stretch of one bit time, 16 ticks.
// - Each received pulse that starts while no stretch is running drives the UART receive output low for one bit time, high otherwise.
// - There are no registers; a single enable input, off after reset, controls the block.
// - While disabled the infrared output is 0 and the UART receive output is 1.
package irc_pkg;
   localparam logic [3:0] IRC_TX_DELAY = 4'h7;
   localparam logic [3:0] IRC_TX_PULSE = 4'h3;
   localparam logic [4:0] IRC_BIT_TICKS = 5'h10;
   localparam int IRC_FIFO_DEPTH = 8;
   localparam int IRC_EDGE_W = 1;
   localparam logic IRC_ENABLE_RST = 1'b0;
   localparam logic IRC_TX_IDLE = 1'b0;
   localparam logic IRC_RX_IDLE = 1'b1;

   typedef enum logic [1:0] {
      IRC_TX_WAIT_E = 2'b00,
      IRC_TX_DELAY_E = 2'b01,
      IRC_TX_HIGH_E = 2'b10
   } irc_tx_state_e;

   // Synchroniser pair and edge register for one pin
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } irc_sync_s;
endpackage

// >>> design/irc_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
module irc_fifo
   import irc_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   // Pointer and fill level arithmetic
   always_comb begin
      push = in_valid && (count != DEPTH[AW:0]);
      pop = out_ready && (count != '0);
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
   end

   // State registers and storage
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
endmodule

// >>> sim/irc_codec_asserts.sv
// Port checker for the infrared pulse codec
module irc_codec_chk
   import irc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic codec_enable,
   input wire logic oversample_tick,
   input wire logic uart_tx_in,
   input wire logic ir_rx_in,
   input wire logic ir_tx_out,
   input wire logic uart_rx_out,
   input wire logic tx_overflow
);
   logic [3:0] pcnt;
   logic [4:0] scnt;
   // Ticks sampled on the same edges that see the pulse or stretch showing
   always_ff @(posedge sys_clk) begin
      pcnt <= !ir_tx_out ? 4'h0 : 4'(pcnt + 4'(oversample_tick));
      scnt <= uart_rx_out ? 5'h00 : 5'(scnt + 5'(oversample_tick));
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence en_s; codec_enable[*4]; endsequence
   sequence space_s; !uart_rx_out[*8]; endsequence
   rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> !ir_tx_out && uart_rx_out && !tx_overflow)
      else $error("outputs not idle after reset");
   byp_tx_a: assert property (!codec_enable[*4] |-> !ir_tx_out) else $error("ir out high while off");
   byp_rx_a: assert property (!codec_enable[*4] |-> uart_rx_out) else $error("rx out low while off");
   pulse_len_a: assert property ($fell(ir_tx_out) && codec_enable |-> pcnt == IRC_TX_PULSE)
      else $error("pulse width wrong");
   stretch_len_a: assert property ($rose(uart_rx_out) && codec_enable |-> scnt == IRC_BIT_TICKS)
      else $error("space length wrong");
   rx_start_a: assert property (en_s ##0 ($fell(ir_rx_in) && uart_rx_out) |-> ##4 !uart_rx_out)
      else $error("space not started");
   tx_tick_a: assert property ($rose(ir_tx_out) |-> $past(oversample_tick, 2)) else $error("pulse off tick");
   space_hold_a: assert property ($fell(uart_rx_out) |=> space_s) else $error("space cut short");
   ovf_hold_a: assert property (tx_overflow && codec_enable |=> tx_overflow) else $error("overflow lost");
endmodule
bind irc_codec irc_codec_chk irc_codec_chk_i (.sys_clk, .sys_rst, .codec_enable, .oversample_tick,
   .uart_tx_in, .ir_rx_in, .ir_tx_out, .uart_rx_out, .tx_overflow);

// >>> sim/irc_partner.sv
// Model of the UART transmit line and the infrared transceiver
module irc_partner (
   input wire logic sys_clk,
   input wire logic oversample_tick,
   output logic uart_tx_in,
   output logic ir_rx_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Both lines idle high
   initial begin
      uart_tx_in = 1'b1;
      ir_rx_in = 1'b1;
   end
   // Wait n ticks, then step off the sampling edge
   task automatic wait_ticks(input int n);
      repeat (n) @(posedge sys_clk iff oversample_tick);
      @(negedge sys_clk);
   endtask
   // Hold the UART line at one level
   task automatic uart_level(input logic b, input int n);
      uart_tx_in = b;
      wait_ticks(n);
   endtask
   // Short transceiver pulse, well inside a bit
   task automatic ir_pulse();
      ir_rx_in = 1'b0;
      wait_ticks(3);
      ir_rx_in = 1'b1;
   endtask
endmodule

// >>> sim/irc_codec_tb.sv
// Self-checking bench for the infrared pulse codec
module irc_codec_tb
   import irc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, sys_rst = 1, codec_enable = 0, oversample_tick = 0;
   logic uart_tx_in, ir_rx_in, ir_tx_out, uart_rx_out, tx_overflow, tx_last, tx_hi, rx_lo;
   int miscompares = 0, samples_checked = 0, div = 0, gap = 0, tlen = 0, rlen = 0;
   int tx_q[$], rx_q[$], gap_q[$];
   always #5 sys_clk = ~sys_clk;
   // Tick on every fourth clock
   always @(negedge sys_clk) begin
      div = (div + 1) % 4;
      oversample_tick = (div == 0);
   end
   irc_codec irc_codec_i (.sys_clk, .sys_rst, .codec_enable, .oversample_tick, .uart_tx_in, .ir_rx_in,
      .ir_tx_out, .uart_rx_out, .tx_overflow);
   irc_partner irc_partner_i (.sys_clk, .oversample_tick, .uart_tx_in, .ir_rx_in);
   // Tick counts of delays, pulses and spaces, taken after each edge
   always begin
      @(posedge sys_clk);
      #1;
      if (tx_last && !uart_tx_in) gap = 0;
      else if (oversample_tick) gap++;
      tx_last = uart_tx_in;
      if (ir_tx_out && !tx_hi) gap_q.push_back(gap);
      if (!ir_tx_out && tx_hi) tx_q.push_back(tlen + int'(oversample_tick));
      tlen = (ir_tx_out && tx_hi) ? tlen + int'(oversample_tick) : 0;
      tx_hi = ir_tx_out;
      if (uart_rx_out && rx_lo) rx_q.push_back(rlen + int'(oversample_tick));
      rlen = (!uart_rx_out && rx_lo) ? rlen + int'(oversample_tick) : 0;
      rx_lo = !uart_rx_out;
   end
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Idle after reset, traffic ignored while off
   task automatic t_bypass();
      check_val(16'({ir_tx_out, uart_rx_out, tx_overflow}), 16'h0002);
      irc_partner_i.uart_level(1'b0, 4);
      irc_partner_i.uart_level(1'b1, 4);
      irc_partner_i.ir_pulse();
      irc_partner_i.wait_ticks(4);
      check_val(16'(tx_q.size() + rx_q.size() + gap_q.size()), 16'h0000);
   endtask
   // Two spaces on the UART line give two timed pulses
   task automatic t_encode();
      codec_enable = 1'b1;
      irc_partner_i.wait_ticks(2);
      repeat (2) begin
         irc_partner_i.uart_level(1'b0, 16);
         irc_partner_i.uart_level(1'b1, 16);
      end
      check_val(16'(tx_q.size()), 16'h0002);
      check_val(16'(tx_q[1]), 16'(IRC_TX_PULSE));
      check_val(16'(gap_q[0]), 16'(IRC_TX_DELAY) + 16'h0001);
   endtask
   // Second pulse inside a stretch is dropped, a later one is not
   task automatic t_decode();
      irc_partner_i.ir_pulse();
      irc_partner_i.wait_ticks(3);
      irc_partner_i.ir_pulse();
      irc_partner_i.wait_ticks(20);
      irc_partner_i.ir_pulse();
      irc_partner_i.wait_ticks(20);
      check_val(16'(rx_q.size()), 16'h0002);
      check_val(16'(rx_q[0]), 16'(IRC_BIT_TICKS));
      check_val(16'(rx_q[1]), 16'(IRC_BIT_TICKS));
   endtask
   // Edge burst overfills the queue, disable clears it
   task automatic t_overflow();
      repeat (12) begin
         irc_partner_i.uart_level(1'b0, 1);
         irc_partner_i.uart_level(1'b1, 1);
      end
      check_val(16'(tx_overflow), 16'h0001);
      codec_enable = 1'b0;
      irc_partner_i.wait_ticks(2);
      check_val(16'({tx_overflow, ir_tx_out, uart_rx_out}), 16'h0001);
   endtask
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      wrap_up();
   end
   // Reset, then the scenarios in turn
   initial begin
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      @(negedge sys_clk);
      t_bypass();
      t_encode();
      t_decode();
      t_overflow();
      wrap_up();
   end
endmodule
